// ---- rtl/lane_masked_write.sv ----
// write port of a two-beat burst sram with per-lane write masking
// Behaviour
// - low select 0 only writes lower lane
// - low select 1 only writes upper lane
// - both narrow selects high write nothing
// - mask sampled separately on every beat
// - all four selects low write whole word
// - single low wide select writes its lane
// - all four wide selects high write nothing
`timescale 1ns/1ps
`include "lane_mask_cfg.svh"
module lane_masked_write
	import lane_mask_pkg::*;
#(
	parameter int LANES = `LANES_WIDE,
	parameter int LANE_W = `LANE_W_X36,
	parameter int AW = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic beat_pos,
	input wire logic beat_neg,
	input wire logic write_port_select_n,
	input wire logic [AW-1:0] addr,
	input wire logic [LANES*LANE_W-1:0] wdata,
	input wire logic [LANES-1:0] lane_write_select_n,
	input wire logic [AW:0] rd_loc,
	output logic [LANES*LANE_W-1:0] rd_data,
	output logic busy
);
	import lane_mask_pkg::*;
	// lane count and width set the organisation: 4x9, 2x9 or 2x4
	localparam int DW = LANES * LANE_W;
	localparam int DEPTH = 2 ** (AW + 1);

	// two-flop synchronisers for the write-side pin inputs; rd_loc and rst are not synchronised
	// a pin level sampled on one edge reaches the capture two cycles later
	logic [DW+LANES+AW+2:0] s1_reg, s2_reg;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= {beat_pos, beat_neg, write_port_select_n, addr,
				lane_write_select_n, wdata};
			s2_reg <= s1_reg;
		end
	end

	logic p_s, n_s, wps_s;
	logic [AW-1:0] a_s;
	logic [LANES-1:0] m_s;
	logic [DW-1:0] d_s;
	assign {p_s, n_s, wps_s, a_s, m_s, d_s} = s2_reg;

	// edge detect the two beat strobes
	// reset low matches the idle pin level, so no false beat follows reset
	logic p_q_reg, n_q_reg;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			p_q_reg <= 1'b0;
			n_q_reg <= 1'b0;
		end else begin
			p_q_reg <= p_s;
			n_q_reg <= n_s;
		end
	end
	logic p_rise, n_rise;
	assign p_rise = p_s & ~p_q_reg;
	assign n_rise = n_s & ~n_q_reg;

	// burst state and first-beat capture
	wr_state_t st_reg, st_next;
	logic [DW-1:0] d0_reg, d0_next;
	logic [LANES-1:0] m0_reg, m0_next;
	logic we_next, we_reg;
	logic [AW:0] wl_next, wl_reg;
	logic [DW-1:0] wd_next, wd_reg;
	logic [LANES-1:0] wm_next, wm_reg;
	// one array word per beat: depth is twice the address range
	logic [DW-1:0] mem [0:DEPTH-1];
	logic [DW-1:0] merged1;
	logic [AW:0] base_loc;
	// the second beat is staged here so the array takes one word a cycle
	logic pend_reg, pend_next;
	logic [DW-1:0] d1_reg, d1_next;
	logic [LANES-1:0] m1_reg, m1_next;
	// the address comes with the second beat, so the base is formed late
	assign base_loc = {a_s, 1'b0};

	// merge the staged beat with the word it replaces
	// the old word is read in the cycle it is replaced
	lane_merge #(.LANES(LANES), .LANE_W(LANE_W)) u_merge (
		.old_word(mem[wl_reg]),
		.new_word(wd_reg),
		.sel_n(wm_reg),
		.merged(merged1)
	);

	// a start needs the port select low at the positive strobe
	always_comb begin
		st_next = st_reg;
		d0_next = d0_reg;
		m0_next = m0_reg;
		we_next = 1'b0;
		wl_next = wl_reg;
		wd_next = wd_reg;
		wm_next = wm_reg;
		unique case (st_reg)
			wr_idle: begin
				if (p_rise && !wps_s) begin
					d0_next = d_s;
					m0_next = m_s;
					st_next = wr_beat1;
				end
			end
			wr_beat1: begin
				if (n_rise) begin
					// first beat to base location
					we_next = 1'b1;
					wl_next = base_loc;
					wd_next = d0_reg;
					wm_next = m0_reg;
					st_next = wr_idle;
				end
			end
		endcase
		if (pend_reg) begin
			// hand the staged second beat to the merge at base+1
			we_next = 1'b1;
			wl_next = wl_reg + 1'b1;
			wd_next = d1_reg;
			wm_next = m1_reg;
		end
	end

	// second beat is captured on the negative strobe, one cycle behind
	always_comb begin
		pend_next = 1'b0;
		d1_next = d1_reg;
		m1_next = m1_reg;
		if (st_reg == wr_beat1 && n_rise) begin
			pend_next = 1'b1;
			d1_next = d_s;
			m1_next = m_s;
		end
	end

	// a staged beat with every select high leaves memory untouched
	logic pend_we, write_now;
	logic [AW:0] loc_now;
	logic [DW-1:0] dat_now;
	logic [LANES-1:0] msk_now;
	always_comb begin
		write_now = we_reg;
		loc_now = wl_reg;
		dat_now = merged1;
		msk_now = wm_reg;
		pend_we = pend_reg;
	end

	// busy covers capture, staging and both array writes
	// it is registered so the output comes straight from a flop
	logic busy_next;
	always_comb begin
		busy_next = (st_next != wr_idle) | pend_next | pend_we | write_now;
	end

	// burst and staging registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_reg <= wr_idle;
			d0_reg <= '0;
			m0_reg <= '1;
			d1_reg <= '0;
			m1_reg <= '1;
			pend_reg <= 1'b0;
			we_reg <= 1'b0;
			wl_reg <= '0;
			wd_reg <= '0;
			wm_reg <= '1;
		end else begin
			st_reg <= st_next;
			d0_reg <= d0_next;
			m0_reg <= m0_next;
			d1_reg <= d1_next;
			m1_reg <= m1_next;
			pend_reg <= pend_next;
			we_reg <= we_next;
			wl_reg <= wl_next;
			wd_reg <= wd_next;
			wm_reg <= wm_next;
		end
	end

	// true when every lane of a beat is masked off
	function automatic logic none_sel(input logic [LANES-1:0] sel);
		return &sel;
	endfunction

	// array write: masked lanes keep their old contents
	// the array is not reset, so unwritten words read back unknown
	always_ff @(posedge mclk) begin
		if (write_now && !none_sel(msk_now)) begin
			mem[loc_now] <= dat_now;
		end
	end

	// registered read-back and busy flag
	// read-back gives no forwarding of a write in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
			busy <= 1'b0;
		end else begin
			rd_data <= mem[rd_loc];
			busy <= busy_next;
		end
	end
endmodule // lane_masked_write

// ---- rtl/lane_mask_cfg.svh ----
// constants for the lane-masked write port
`ifndef LANE_MASK_CFG_SVH
`define LANE_MASK_CFG_SVH
`define ORG_X8 2'h0
`define ORG_X18 2'h1
`define ORG_X36 2'h2
`define LANE_W_X8 4
`define LANE_W_X18 9
`define LANE_W_X36 9
`define LANES_NARROW 2
`define LANES_WIDE 4
`define BEAT_LAST 1'h1
`endif

// ---- rtl/lane_mask_pkg.sv ----
// types shared by the lane-masked write port
package lane_mask_pkg;
	typedef enum logic [1:0] {org_x8, org_x18, org_x36} org_t;
	typedef enum logic [1:0] {wr_idle, wr_beat1} wr_state_t;
endpackage

// ---- rtl/lane_merge.sv ----
// per-lane merge of new beat data with stored word
`timescale 1ns/1ps
module lane_merge #(
	parameter int LANES = 4,
	parameter int LANE_W = 9
) (
	input wire logic [LANES*LANE_W-1:0] old_word,
	input wire logic [LANES*LANE_W-1:0] new_word,
	input wire logic [LANES-1:0] sel_n,
	output logic [LANES*LANE_W-1:0] merged
);
	// a low select takes the new lane, a high one keeps the old
	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_lane
			assign merged[g*LANE_W +: LANE_W] = sel_n[g] ?
				old_word[g*LANE_W +: LANE_W] :
				new_word[g*LANE_W +: LANE_W];
		end
	endgenerate
endmodule // lane_merge

// ---- verif/ctl_model.sv ----
// controller model for the write port pins
`timescale 1ns/1ps
module ctl_model (
	input wire logic mclk,
	output logic pos,
	output logic neg,
	output logic sel_n,
	output logic [3:0] adr,
	output logic [35:0] d,
	output logic [3:0] m
);
	initial begin
		{pos, neg, sel_n, adr, d, m} = {3'h1, 4'h0, 36'h0, 4'hf};
	end
	// two beats, every level held 3 cycles, data inverted once released
	task automatic burst(input logic [3:0] a, input logic [35:0] d0, d1,
		input logic [3:0] m0, m1);
		@(negedge mclk) {pos, sel_n, d, m} <= {2'h2, d0, m0};
		repeat (3) @(negedge mclk);
		{pos, sel_n, neg, adr, d, m} <= {3'h3, a, d1, m1};
		repeat (3) @(negedge mclk);
		{neg, d, m} <= {1'h0, ~d1, 4'hf};
		repeat (6) @(negedge mclk);
	endtask
	// both strobes with the port deselected, which the port must ignore
	task automatic stray(input logic [3:0] a, input logic [35:0] dv);
		@(negedge mclk) {pos, sel_n, d, m} <= {2'h3, dv, 4'h0};
		repeat (3) @(negedge mclk);
		{pos, neg, adr} <= {2'h1, a};
		repeat (3) @(negedge mclk);
		{neg, sel_n} <= 2'h1;
		repeat (6) @(negedge mclk);
	endtask
endmodule // ctl_model

// ---- verif/lane_masked_write_properties.sv ----
// port checks for the masked write port
`timescale 1ns/1ps
module lane_masked_write_properties #(
	parameter int LANES = 4,
	parameter int LANE_W = 9,
	parameter int AW = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic beat_pos,
	input wire logic beat_neg,
	input wire logic write_port_select_n,
	input wire logic [AW:0] rd_loc,
	input wire logic [LANES*LANE_W-1:0] rd_data,
	input wire logic busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// a taken burst start
	sequence go_s;
		$rose(beat_pos) && !write_port_select_n;
	endsequence
	// a start refused by a high port select
	sequence refused_s;
		!busy && $rose(beat_pos) && write_port_select_n;
	endsequence
	// a second-beat strobe with no burst open
	sequence stray_neg_s;
		!busy && $rose(beat_neg);
	endsequence
	// the port has been quiet for three cycles
	sequence quiet_s;
		!busy [*3];
	endsequence
	a_start_busy: assert property (go_s |-> ##[1:6] busy)
		else $error("no busy after start");
	// busy follows a taken start after the capture pipeline
	a_start_delay: assert property (go_s |-> ##3 busy)
		else $error("busy late after start");
	// an idle port keeps stored words
	a_idle_keep: assert property (quiet_s ##0 $stable(rd_loc) |=>
		$stable(rd_data)) else $error("rd_data moved while idle");
	// a deselected start opens no burst
	a_refused_quiet: assert property (refused_s |=> !busy [*5])
		else $error("busy after refused start");
	// a second strobe alone opens no burst
	a_stray_neg: assert property (stray_neg_s |=> !busy [*3])
		else $error("busy after stray second beat");
	// a burst stays busy until both beats have been written
	a_burst_span: assert property ($rose(busy) |-> busy [*6])
		else $error("busy dropped before both beats");
endmodule // lane_masked_write_properties
bind lane_masked_write lane_masked_write_properties #(.LANES(LANES),
	.LANE_W(LANE_W), .AW(AW)) chk_u (.mclk(mclk), .rst(rst),
	.beat_pos(beat_pos), .beat_neg(beat_neg),
	.write_port_select_n(write_port_select_n),
	.rd_loc(rd_loc), .rd_data(rd_data), .busy(busy));

// ---- verif/lane_masked_write_tb.sv ----
// bench for the masked write port
`timescale 1ns/1ps
module lane_masked_write_tb;
	logic mclk, rst, pos, neg, sel_n, busy, busy_nar;
	logic [17:0] rd_nar;
	logic [3:0] a, m;
	logic [4:0] rd_loc;
	logic [35:0] d, rd_data;
	int mismatches, cmp_count, cyc;
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	ctl_model p (.mclk(mclk), .pos(pos), .neg(neg), .sel_n(sel_n),
		.adr(a), .d(d), .m(m));
	lane_masked_write dut_u (.mclk(mclk), .rst(rst), .beat_pos(pos),
		.beat_neg(neg), .write_port_select_n(sel_n), .addr(a), .wdata(d),
		.lane_write_select_n(m), .rd_loc(rd_loc), .rd_data(rd_data),
		.busy(busy));
	// a two-lane port on the same pins covers the 2x9 narrow organisation
	if (1) begin : g_x18
		lane_masked_write #(.LANES(2), .LANE_W(9)) dut_u (.mclk(mclk),
			.rst(rst), .beat_pos(pos), .beat_neg(neg),
			.write_port_select_n(sel_n), .addr(a), .wdata(d[17:0]),
			.lane_write_select_n(m[1:0]), .rd_loc(rd_loc),
			.rd_data(rd_nar), .busy(busy_nar));
	end
	function automatic logic [35:0] mrg(logic [35:0] o, n, logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (!s[i])
				o[i*9+:9] = n[i*9+:9];
		return o;
	endfunction
	task automatic close_out();
		$display("errors %0d checks %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// read a location once the port is quiet
	task automatic rd_chk(input logic [4:0] l, input logic [35:0] e);
		while (busy !== 1'h0 || busy_nar !== 1'h0)
			@(negedge mclk);
		rd_loc = l;
		repeat (2) @(negedge mclk);
		cmp_count++;
		if (rd_data !== e) begin
			mismatches++;
			$display("CHECK FAILED rd_data exp %h got %h", e, rd_data);
		end
		cmp_count++;
		if (rd_nar !== e[17:0]) begin
			mismatches++;
			$display("CHECK FAILED rd_nar exp %h got %h", e[17:0], rd_nar);
		end
	endtask
	task automatic t_lane();
		logic [3:0] s;
		for (int n = 0; n < 4; n++) begin
			s = ~(4'h1 << n);
			p.burst(4'h5, 36'h0, ~36'h0, 4'h0, 4'h0);
			p.burst(4'h5, ~36'h0, 36'h0, s, {s[0], s[3:1]});
			rd_chk(5'h0a, mrg(36'h0, ~36'h0, s));
			rd_chk(5'h0b, mrg(~36'h0, 36'h0, {s[0], s[3:1]}));
		end
	endtask
	task automatic t_none();
		p.burst(4'h9, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
		p.burst(4'h9, 36'h0, 36'h0, 4'hf, 4'h0);
		rd_chk(5'h12, 36'h111111111);
		rd_chk(5'h13, 36'h0);
	endtask
	// a deselected start leaves both words as they were
	task automatic t_refuse();
		p.burst(4'h3, 36'h3c3c3c3c3, 36'h5a5a5a5a5, 4'h0, 4'h0);
		p.stray(4'h3, 36'h0);
		rd_chk(5'h06, 36'h3c3c3c3c3);
		rd_chk(5'h07, 36'h5a5a5a5a5);
	endtask
	initial begin
		rst = 1'h1;
		rd_loc = 5'h00;
		repeat (12) @(negedge mclk);
		rst = 1'h0;
		repeat (3) @(negedge mclk);
		t_lane();
		t_none();
		t_refuse();
		close_out();
	end
	// cut a hang short
	always @(posedge mclk) begin
		if (++cyc > 2000) begin
			mismatches++;
			close_out();
		end
	end
endmodule // lane_masked_write_tb
